// ### logic/wct_timer.sv
/*
 * Watch clock timer: 8-bit tap counter, high-half hold, run/clear control,
 * seven falling-edge interrupt flags with enables, AHB-Lite slave.
 * Assumes tick_256hz_in is a one-cycle pulse from logic on ref_clk_in.
 */
`timescale 1ns/1ps

// Behaviour
// - Eight-bit up-counter on divided crystal tick, bits toggle 128 Hz to 1 Hz.
// - Low data register shows 128..16 Hz taps, high shows 8..1 Hz.
// - Both data registers are read-only; writes leave the counter alone.
// - Low read freezes carries to high half until high read or timeout.
// - System reset clears all counter bits.
// - Writing one to clear bit zeroes counter; bit reads as zero.
// - Clear while running keeps counting from zero; while stopped stays zero.
// - Run bit at bit 0 starts or stops counting; reset clears it.
// - Stopped counter holds value and resumes from it when run again.
// - Seven enable bits split over two registers, one enables, reset zero.
// - Seven flags in same arrangement over two registers, reset zero.
// - Flag sets on falling edge of its tap regardless of enable.
// - Writing one clears a flag, writing zero does nothing.
// - Interrupt stays requested while any enabled flag remains set.
module wct_timer #(
  parameter int HOLD_CYCLES = wct_pkg::HOLD_CYCLES
) (
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        clk_en_in,
  input  wire logic        tick_256hz_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  output logic             irq_out
);

  initial
  begin
    if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << wct_pkg::HOLD_CW))
      $error("HOLD_CYCLES out of range");
  end

  wct_pkg::wct_state_t s_q;
  wct_pkg::wct_state_t s_d;

  // Flag order: 32,8,2,1 Hz (a) then 16,64,128 Hz (b); count bit of each
  function automatic logic [6:0] taps(input logic [7:0] c);
    taps = {c[0], c[1], c[3], c[7], c[6], c[4], c[2]};
  endfunction : taps

  function automatic logic [31:0] rd_mux(input wct_pkg::wct_state_t s);
    rd_mux = 32'h0000_0000;
    case (s.didx)
      wct_pkg::IDX_CONTROL:   rd_mux[0]   = s.run;
      wct_pkg::IDX_DATA_LOW:  rd_mux[3:0] = s.count[3:0];
      wct_pkg::IDX_DATA_HIGH: rd_mux[3:0] = s.count[7:4];
      wct_pkg::IDX_ENABLE_A:  rd_mux[3:0] = s.enable[3:0];
      wct_pkg::IDX_ENABLE_B:  rd_mux[2:0] = s.enable[6:4];
      wct_pkg::IDX_FLAGS_A:   rd_mux[3:0] = s.flags[3:0];
      wct_pkg::IDX_FLAGS_B:   rd_mux[2:0] = s.flags[6:4];
      default:                rd_mux      = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  logic        aphase;
  logic        wr_dp;
  logic        rd_low;
  logic        rd_high;
  logic [7:0]  cnt_inc;
  logic [6:0]  fall;
  logic [6:0]  clr;

  // Enable and flag vectors: register a in [3:0], register b in [6:4]
  assign aphase = hsel_in && hready_in && htrans_in[1];

  always_comb
  begin
    s_d     = s_q;
    wr_dp   = s_q.dph && s_q.dwrite;
    rd_low  = aphase && !hwrite_in && (haddr_in[17:2] == wct_pkg::IDX_DATA_LOW);
    rd_high = aphase && !hwrite_in && (haddr_in[17:2] == wct_pkg::IDX_DATA_HIGH);
    cnt_inc = s_q.count;
    clr     = 7'h00;

    // ===================================================================
    // Bus address phase
    // ===================================================================
    s_d.dph    = aphase;
    s_d.dwrite = hwrite_in;
    s_d.didx   = haddr_in[17:2];
    // Read data is captured at the address phase, so a high read returns the
    // held half even though that same read releases the hold.
    // Limitation: a read right behind a write sees the state before that write
    if (aphase && !hwrite_in)
      s_d.rdata = rd_mux(s_d);

    // ===================================================================
    // Counter with high-half hold
    // ===================================================================
    if (s_q.run && tick_256hz_in)
    begin
      cnt_inc[3:0] = s_q.count[3:0] + 4'h1;
      if (s_q.count[3:0] == 4'hF)
      begin
        if (s_q.hold)
          s_d.pend_carry = 1'b1;
        else
          cnt_inc[7:4] = s_q.count[7:4] + 4'h1;
      end
    end
    if (rd_low)
    begin
      s_d.hold     = 1'b1;
      s_d.hold_cnt = '0;
    end
    else if (s_q.hold)
    begin
      s_d.hold_cnt = s_q.hold_cnt + 1'b1;
      if (rd_high || (int'(s_q.hold_cnt) >= HOLD_CYCLES - 1))
      begin
        s_d.hold = 1'b0;
        if (s_d.pend_carry)
        begin
          cnt_inc[7:4]   = cnt_inc[7:4] + 4'h1;
          s_d.pend_carry = 1'b0;
        end
      end
    end
    s_d.count = cnt_inc;

    // ===================================================================
    // Register writes; data registers ignore writes
    // ===================================================================
    if (wr_dp)
    begin
      case (s_q.didx)
        wct_pkg::IDX_CONTROL:
        begin
          s_d.run = hwdata_in[wct_pkg::RUN_BIT];
          if (hwdata_in[wct_pkg::CLEAR_BIT])
          begin
            s_d.count      = wct_pkg::COUNT_RESET;
            s_d.pend_carry = 1'b0;
          end
        end
        wct_pkg::IDX_ENABLE_A: s_d.enable[3:0] = hwdata_in[3:0];
        wct_pkg::IDX_ENABLE_B: s_d.enable[6:4] = hwdata_in[2:0];
        wct_pkg::IDX_FLAGS_A:  clr[3:0]        = hwdata_in[3:0];
        wct_pkg::IDX_FLAGS_B:  clr[6:4]        = hwdata_in[2:0];
        default: ;
      endcase
    end

    // Set wins over a same-cycle clear
    fall      = taps(s_q.count) & ~taps(s_d.count);
    s_d.flags = (s_q.flags & ~clr) | fall;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      s_q        <= '0;
      s_q.count  <= wct_pkg::COUNT_RESET;
      s_q.enable <= wct_pkg::IRQ_RESET;
      s_q.flags  <= wct_pkg::IRQ_RESET;
    end
    else if (clk_en_in)
      s_q <= s_d;
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = s_q.rdata;
  assign irq_out       = |(s_q.flags & s_q.enable);

  // =====================================================================
  // Assertions
  // =====================================================================
  sequence s_tick_wrap;
    s_q.run && tick_256hz_in && clk_en_in && s_q.count[3:0] == 4'hF;
  endsequence

  property p_irq_level;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      irq_out == |(s_q.flags & s_q.enable);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

  property p_reset_zero;
    @(posedge ref_clk_in)
      !resetn_in |=> (s_q.count == 8'h00 && !s_q.run && s_q.flags == 7'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset state");

  property p_stop_holds;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (!s_q.run && !wr_dp && clk_en_in && !s_q.pend_carry) |=> $stable(s_q.count);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("count moved");

  property p_clear;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (wr_dp && clk_en_in && s_q.didx == wct_pkg::IDX_CONTROL && hwdata_in[1])
        |=> s_q.count == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_hold_freeze;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (s_tick_wrap and s_q.hold && !rd_high && !wr_dp
        && (int'(s_q.hold_cnt) < HOLD_CYCLES - 1)) |=> $stable(s_q.count[7:4]);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("hold broken");

  property p_flag_set;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && |fall) |=> ((s_q.flags & $past(fall)) == $past(fall));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_clr;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && clr[0] && !fall[0]) |=> !s_q.flags[0];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_ro_data;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && wr_dp && s_q.didx == wct_pkg::IDX_DATA_LOW && !s_q.run && !s_q.hold)
        |=> $stable(s_q.count);
  endproperty
  a_ro_data: assert property (p_ro_data) else $error("data written");

  property p_ro_high;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && wr_dp && s_q.didx == wct_pkg::IDX_DATA_HIGH && !s_q.run && !s_q.hold)
        |=> $stable(s_q.count);
  endproperty
  a_ro_high: assert property (p_ro_high) else $error("high data written");

  // =====================================================================
  // Counting, control and hold
  // =====================================================================
  sequence s_tick_run;
    s_q.run && tick_256hz_in && clk_en_in && !wr_dp;
  endsequence

  sequence s_ctrl_write;
    wr_dp && clk_en_in && s_q.didx == wct_pkg::IDX_CONTROL;
  endsequence

  property p_low_step;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      s_tick_run |=> s_q.count[3:0] == $past(s_q.count[3:0]) + 4'h1;
  endproperty
  a_low_step: assert property (p_low_step) else $error("low half no step");

  property p_carry_free;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (s_tick_run and s_q.count[3:0] == 4'hF && !s_q.hold)
        |=> s_q.count[7:4] == $past(s_q.count[7:4]) + 4'h1;
  endproperty
  a_carry_free: assert property (p_carry_free) else $error("carry lost");

  property p_run_write;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      s_ctrl_write |=> s_q.run == $past(hwdata_in[0]);
  endproperty
  a_run_write: assert property (p_run_write) else $error("run bit wrong");

  property p_clear_run;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (s_ctrl_write and hwdata_in[1] && hwdata_in[0]) |=> (s_q.count == 8'h00 && s_q.run);
  endproperty
  a_clear_run: assert property (p_clear_run) else $error("clear in run");

  property p_hold_start;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && rd_low) |=> s_q.hold;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold not taken");

  property p_hold_end;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && s_q.hold && rd_high) |=> !s_q.hold;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("hold not released");

  // Hold length is bounded through its own counter
  property p_hold_limit;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      s_q.hold |-> int'(s_q.hold_cnt) < HOLD_CYCLES;
  endproperty
  a_hold_limit: assert property (p_hold_limit) else $error("hold too long");

  property p_carry_late;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && s_q.hold && s_q.pend_carry && rd_high && !wr_dp)
        |=> s_q.count[7:4] == $past(s_q.count[7:4]) + 4'h1;
  endproperty
  a_carry_late: assert property (p_carry_late) else $error("held carry lost");

  property p_freeze;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      !clk_en_in |=> $stable(s_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // =====================================================================
  // Enables, flags and interrupt
  // =====================================================================
  property p_enable_a;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (wr_dp && clk_en_in && s_q.didx == wct_pkg::IDX_ENABLE_A)
        |=> s_q.enable[3:0] == $past(hwdata_in[3:0]);
  endproperty
  a_enable_a: assert property (p_enable_a) else $error("enable a wrong");

  property p_enable_b;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (wr_dp && clk_en_in && s_q.didx == wct_pkg::IDX_ENABLE_B)
        |=> s_q.enable[6:4] == $past(hwdata_in[2:0]);
  endproperty
  a_enable_b: assert property (p_enable_b) else $error("enable b wrong");

  property p_flag_clr_b;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && clr[6] && !fall[6]) |=> !s_q.flags[6];
  endproperty
  a_flag_clr_b: assert property (p_flag_clr_b) else $error("flag b not cleared");

  property p_flag_keep;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && !clr[0] && s_q.flags[0]) |=> s_q.flags[0];
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag lost");

  property p_irq_rise;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && !wr_dp && |(fall & s_q.enable)) |=> irq_out;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq not raised");

  // =====================================================================
  // Read data
  // =====================================================================
  property p_rd_low;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && aphase && !hwrite_in && haddr_in[17:2] == wct_pkg::IDX_DATA_LOW)
        |=> hrdata_out == {28'h0000000, $past(s_q.count[3:0])};
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("low read wrong");

  property p_rd_high;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && aphase && !hwrite_in && haddr_in[17:2] == wct_pkg::IDX_DATA_HIGH)
        |=> hrdata_out == {28'h0000000, $past(s_q.count[7:4])};
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("high read wrong");

  property p_rd_ctrl;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && aphase && !hwrite_in && haddr_in[17:2] == wct_pkg::IDX_CONTROL)
        |=> hrdata_out[31:1] == 31'h00000000;
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

  property p_rd_enb;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (clk_en_in && aphase && !hwrite_in && haddr_in[17:2] == wct_pkg::IDX_ENABLE_B)
        |=> hrdata_out[31:3] == 29'h00000000;
  endproperty
  a_rd_enb: assert property (p_rd_enb) else $error("unused bits read");

endmodule : wct_timer

// ### logic/wct_pkg.sv
/*
 * Package for the watch clock timer: register offsets, field positions,
 * reset values, timing constants and the carrier struct.
 * Assumes a 20 MHz system clock and a 256 Hz count enable from a prescaler.
 */
package wct_pkg;

  // =====================================================================
  // Register map (printed offsets are not multiples of four: kept as index)
  // =====================================================================
  localparam logic [15:0] IDX_CONTROL   = 16'hFF74;
  localparam logic [15:0] IDX_DATA_LOW  = 16'hFF75;
  localparam logic [15:0] IDX_DATA_HIGH = 16'hFF76;
  localparam logic [15:0] IDX_ENABLE_A  = 16'hFFE5;
  localparam logic [15:0] IDX_ENABLE_B  = 16'hFFE9;
  localparam logic [15:0] IDX_FLAGS_A   = 16'hFFF5;
  localparam logic [15:0] IDX_FLAGS_B   = 16'hFFF9;

  // =====================================================================
  // Field positions
  // =====================================================================
  localparam int RUN_BIT   = 0;
  localparam int CLEAR_BIT = 1;

  // =====================================================================
  // Reset values
  // =====================================================================
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [6:0] IRQ_RESET   = 7'h00;

  // =====================================================================
  // Timing
  // =====================================================================
  localparam int CLK_HZ        = 20000000;
  localparam int HOLD_MIN_US   = 480;
  localparam int HOLD_MAX_US   = 1500;
  // Hold length sits inside the window; exactly the minimum, no rounding
  localparam int HOLD_CYCLES   = (HOLD_MIN_US * (CLK_HZ / 1000000));
  localparam int HOLD_CW       = 15;

  typedef struct packed {
    logic [7:0]  count;
    logic        run;
    logic [6:0]  enable;
    logic [6:0]  flags;
    logic        hold;
    logic [HOLD_CW-1:0] hold_cnt;
    logic        pend_carry;
    logic        dph;
    logic        dwrite;
    logic [15:0] didx;
    logic [31:0] rdata;
  } wct_state_t;

endpackage : wct_pkg

// ### dv/wct_timer_tb.sv
/*
 * Self-checking bench for wct_timer: random ticks, enables and flag clears
 * against a bench model, plus hold, stop, clear and reset corner cases.
 * Assumes the hold length parameter is shortened to HOLD for simulation.
 */
`timescale 1ns/1ps
module wct_timer_tb;
  // ==================================================================
  // Signals and model state
  // ==================================================================
  localparam int HOLD = 20;
  localparam logic [15:0] ALL_IDX [8] = '{16'hFF74, 16'hFF75, 16'hFF76, 16'hFFE5,
                                           16'hFFE9, 16'hFFF5, 16'hFFF9, 16'hFF77};
  logic        ref_clk_in = 1'b0;
  logic        resetn_in  = 1'b0;
  logic        tick       = 1'b0;
  logic        clk_en     = 1'b1;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'b0;
  logic [31:0] hwdata     = 32'h0;
  wire         hready;
  wire         hresp;
  wire  [31:0] hrdata;
  wire         irq;
  // Flags and enables held as {b[2:0], a[3:0]}
  logic [7:0]  cnt  = 8'h00;
  logic [6:0]  flg  = 7'h00;
  logic [6:0]  en   = 7'h00;
  logic        run  = 1'b0;
  logic [15:0] seed = 16'h002B;
  logic [31:0] rd;
  int          n_fail     = 0;
  int          n_compared = 0;

  always #25 ref_clk_in = ~ref_clk_in;

  wct_timer #(.HOLD_CYCLES(HOLD)) dut_u (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en),
    .tick_256hz_in(tick), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .irq_out(irq)
  );

  // ==================================================================
  // Model functions
  // ==================================================================
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Falling taps, reordered into the flag layout
  function automatic logic [6:0] falls(input logic [7:0] o, input logic [7:0] n);
    logic [7:0] f;
    f = o & ~n;
    falls = {f[0], f[1], f[3], f[7], f[6], f[4], f[2]};
  endfunction : falls

  // ==================================================================
  // Compare and bus tasks
  // ==================================================================
  task automatic chk(input logic [15:0] idx, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch reg %h exp %h got %h", idx, e, g);
    end
  endtask : chk

  task automatic chk_irq(input logic e);
    n_compared++;
    if (irq !== e || hresp !== 1'b0)
    begin
      n_fail++;
      $display("mismatch irq_out exp %b got %b", e, irq);
    end
  endtask : chk_irq

  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge ref_clk_in);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {14'h0, idx, 2'h0};
    @(posedge ref_clk_in);
    while (hready !== 1'b1) @(posedge ref_clk_in);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk_in);
    while (hready !== 1'b1) @(posedge ref_clk_in);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, rd);
  endtask : wr

  task automatic rchk(input logic [15:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0, rd);
    chk(idx, e, rd);
  endtask : rchk

  task automatic tick_n(input int n);
    repeat (n)
    begin
      @(posedge ref_clk_in);
      tick <= 1'b1;
      @(posedge ref_clk_in);
      tick <= 1'b0;
      if (run)
      begin
        flg = flg | falls(cnt, cnt + 8'h01);
        cnt = cnt + 8'h01;
      end
    end
  endtask : tick_n

  // Low read first, high read right after, so the hold never bites here
  task automatic check_all();
    rchk(wct_pkg::IDX_DATA_LOW, {28'h0, cnt[3:0]});
    rchk(wct_pkg::IDX_DATA_HIGH, {28'h0, cnt[7:4]});
    rchk(wct_pkg::IDX_FLAGS_A, {28'h0, flg[3:0]});
    rchk(wct_pkg::IDX_FLAGS_B, {29'h0, flg[6:4]});
    rchk(wct_pkg::IDX_ENABLE_A, {28'h0, en[3:0]});
    rchk(wct_pkg::IDX_ENABLE_B, {29'h0, en[6:4]});
    chk_irq(|(flg & en));
  endtask : check_all

  task automatic zero_check();
    foreach (ALL_IDX[i]) rchk(ALL_IDX[i], 32'h0);
    chk_irq(1'b0);
  endtask : zero_check

  task automatic final_report();
    $display("TB: compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // ==================================================================
  // Sequence
  // ==================================================================
  initial
  begin
    repeat (16) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    zero_check();
    wr(wct_pkg::IDX_CONTROL, 32'hFFFFFFF1);
    run = 1'b1;
    rchk(wct_pkg::IDX_CONTROL, 32'h1);
    tick_n(15);
    rchk(wct_pkg::IDX_DATA_LOW, 32'hF);
    tick_n(1);
    rchk(wct_pkg::IDX_DATA_HIGH, 32'h0);
    rchk(wct_pkg::IDX_DATA_HIGH, 32'h1);
    tick_n(15);
    rchk(wct_pkg::IDX_DATA_LOW, 32'hF);
    tick_n(1);
    repeat (HOLD + 10) @(posedge ref_clk_in);
    rchk(wct_pkg::IDX_DATA_HIGH, 32'h2);
    check_all();
    repeat (6)
    begin
      seed = lfsr(seed);
      en = seed[6:0];
      wr(wct_pkg::IDX_ENABLE_A, {28'hABCDEF0, en[3:0]});
      wr(wct_pkg::IDX_ENABLE_B, {29'h1, en[6:4]});
      tick_n(int'(seed[15:10]));
      check_all();
      seed = lfsr(seed);
      wr(wct_pkg::IDX_FLAGS_A, {28'h0, seed[3:0]});
      wr(wct_pkg::IDX_FLAGS_B, {29'h1, seed[6:4]});
      flg = flg & ~seed[6:0];
      check_all();
    end
    wr(wct_pkg::IDX_DATA_LOW, 32'hF);
    wr(wct_pkg::IDX_DATA_HIGH, 32'hF);
    check_all();
    wr(wct_pkg::IDX_ENABLE_A, 32'hF);
    wr(wct_pkg::IDX_ENABLE_B, 32'h7);
    en = 7'h7F;
    tick_n(2);
    check_all();
    wr(wct_pkg::IDX_CONTROL, 32'h0);
    run = 1'b0;
    tick_n(5);
    check_all();
    wr(wct_pkg::IDX_CONTROL, 32'h1);
    run = 1'b1;
    tick_n(2);
    check_all();
    wr(wct_pkg::IDX_CONTROL, 32'h0);
    run = 1'b0;
    wr(wct_pkg::IDX_CONTROL, 32'h2);
    cnt = 8'h00;
    tick_n(3);
    rchk(wct_pkg::IDX_CONTROL, 32'h0);
    // Clearing may drop taps, so flags are wiped before comparing
    wr(wct_pkg::IDX_FLAGS_A, 32'hF);
    wr(wct_pkg::IDX_FLAGS_B, 32'h7);
    flg = 7'h00;
    check_all();
    wr(wct_pkg::IDX_CONTROL, 32'h1);
    run = 1'b1;
    tick_n(4);
    wr(wct_pkg::IDX_CONTROL, 32'h3);
    cnt = 8'h00;
    tick_n(2);
    wr(wct_pkg::IDX_FLAGS_A, 32'hF);
    wr(wct_pkg::IDX_FLAGS_B, 32'h7);
    flg = 7'h00;
    check_all();
    rchk(wct_pkg::IDX_CONTROL, 32'h1);
    // Ticks while the clock enable is low must leave the count alone
    clk_en <= 1'b0;
    repeat (4)
    begin
      @(posedge ref_clk_in);
      tick <= 1'b1;
      @(posedge ref_clk_in);
      tick <= 1'b0;
    end
    clk_en <= 1'b1;
    check_all();
    resetn_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    zero_check();
    final_report();
  end

  initial
  begin
    #1000000;
    n_fail++;
    final_report();
  end
endmodule : wct_timer_tb
